// ===== src/rate_decode.sv
// Decodes a four-bit rate code to a carrier divider and an enable.
// Assumes the code comes from a register on the same clock.
`timescale 1ns/1ps
module rate_decode (
  // Code in
  input wire logic [3:0] code_i,
  // Decoded rate
  output tag_regs_pkg::rate_sel_t sel_o
);

  // Codes above 3 are unsupported and switch the path off
  wire logic supported = (code_i[3:2] == 2'h0);

  assign sel_o.enable = supported; // R11 R12
  assign sel_o.div = tag_regs_pkg::carrier_div_t'(code_i[1:0]); // R11

endmodule

// ===== src/tag_mode_rate_status_regs.sv
// Mode, bit-rate, tag state and reader frame/ident registers of the tag interface.
// Assumes a byte register port from the SPI front end, commands decoded upstream,
// and tag state, field flag, PPS and RATS events from framing logic on mclk_i.
`timescale 1ns/1ps

// What this block does
// R1: Mode bits 5:4 pick Level-4, Level-3, framing or transparent mode.
// R2: A protocol mode selected by register forces the tag into Level-4.
// R3: Receive no-CRC skips CRC check and keeps CRC bytes in FIFO.
// R4: Receive bit-stream puts raw bits in FIFO, no parity or CRC check.
// R5: Frame options act in Level-3 and framing; in protocol only FIFO frames.
// R6: Transmit no-CRC stops the appended CRC.
// R7: Transmit bit-stream sends FIFO bits raw, no parity, no CRC.
// R8: Power-up loads the six mode bits from config word bits 12 to 7.
// R9: Rate register holds tx code 7:4, rx code 3:0; resets to zero.
// R10: In Level-4 a PPS command overwrites the rate register.
// R11: Rate codes 0 to 3 map to fc/128, fc/64, fc/32, fc/16.
// R12: An unsupported rate code disables that transmit or receive path.
// R13: State display bit 7 shows field power present.
// R14: State display bits 6:4 show the tag state machine state.
// R15: State display is a live view, not stored.
// R16: Reader_frame_and_id bits 7:4 hold the reader frame size index.
// R17: Reader_frame_and_id bits 3:0 hold the assigned card identifier.
// R18: Reader_frame_and_id clears at power-up and on the default command.
// R19: Reader_frame_and_id is captured only in Level-4 protocol mode.
// R20: Default command C2 or C3 returns the rate and Reader_frame_and_id registers to power-up state; mode keeps its value.
// R21: Reserved bits ignore writes and read as zero.
module tag_mode_rate_status_regs (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // Nonvolatile configuration word, valid while config_load_i is high
  input wire logic [15:0] config_word_i,
  input wire logic config_load_i,
  // Direct command strobe from SPI front end
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_byte_i,
  // Register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_hit_o,
  // Live tag state
  input wire logic field_power_present_i,
  input tag_regs_pkg::tag_state_t tag_state_i,
  // PPS negotiated rates
  input wire logic pps_valid_i,
  input wire logic [3:0] pps_tx_code_i,
  input wire logic [3:0] pps_rx_code_i,
  // RATS capture
  input wire logic rats_valid_i,
  input wire logic [3:0] rats_frame_size_i,
  input wire logic [3:0] rats_card_ident_i,
  // Controls to framing engine
  output tag_regs_pkg::op_mode_t op_mode_o,
  output logic force_level_four_o,
  output tag_regs_pkg::frame_opts_t fifo_opts_o,
  output tag_regs_pkg::frame_opts_t direct_opts_o,
  output tag_regs_pkg::rate_sel_t tx_rate_o,
  output tag_regs_pkg::rate_sel_t rx_rate_o,
  output logic set_default_o
);

  // ****************************************************************
  // Decode
  // ****************************************************************
  logic [7:0] mode_ff;
  logic [7:0] nxt_mode;
  logic [7:0] rate_ff;
  logic [7:0] nxt_rate;
  logic [7:0] rats_ff;
  logic [7:0] nxt_rats;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  wire logic set_default = cmd_valid_i &&
    (cmd_byte_i == tag_regs_pkg::SET_DEFAULT_CMD_A ||
     cmd_byte_i == tag_regs_pkg::SET_DEFAULT_CMD_B); // R20
  wire logic init_load = srst_i || set_default; // R20
  wire logic wr_mode = reg_wr_i && (reg_addr_i == tag_regs_pkg::ADDR_MODE);
  wire logic wr_rate = reg_wr_i && (reg_addr_i == tag_regs_pkg::ADDR_RATE);
  wire tag_regs_pkg::op_mode_t cur_mode =
    tag_regs_pkg::op_mode_t'(mode_ff[tag_regs_pkg::MODE_HI:tag_regs_pkg::MODE_LO]);
  wire logic in_level4 = (cur_mode == tag_regs_pkg::MODE_LEVEL4);
  wire logic in_level3 = (cur_mode == tag_regs_pkg::MODE_LEVEL3);
  wire logic in_framing = (cur_mode == tag_regs_pkg::MODE_FRAMING);
  wire logic [7:0] cfg_bits = {2'h0,
    config_word_i[tag_regs_pkg::CFG_WORD_HI:tag_regs_pkg::CFG_WORD_LO]}; // R8
  wire logic [7:0] state_view = {field_power_present_i, tag_state_i, 4'h0}; // R13 R14 R15

  wire tag_regs_pkg::frame_opts_t reg_opts = '{
    rx_no_crc: mode_ff[tag_regs_pkg::RX_NO_CRC_BIT], // R3
    rx_bitstream: mode_ff[tag_regs_pkg::RX_BITSTREAM_BIT], // R4
    tx_no_crc: mode_ff[tag_regs_pkg::TX_NO_CRC_BIT], // R6
    tx_bitstream: mode_ff[tag_regs_pkg::TX_BITSTREAM_BIT] // R7
  };

  // ****************************************************************
  // Next values
  // ****************************************************************
  always_comb begin
    nxt_mode = mode_ff;
    if (config_load_i) begin
      nxt_mode = cfg_bits; // R8
    end else if (wr_mode) begin
      nxt_mode = reg_wdata_i & tag_regs_pkg::MODE_VALID_MASK; // R1 R21
    end
  end

  always_comb begin
    nxt_rate = rate_ff;
    if (init_load) begin
      nxt_rate = tag_regs_pkg::RATE_RESET; // R9
    end else if (pps_valid_i && in_level4) begin
      nxt_rate = {pps_tx_code_i, pps_rx_code_i}; // R10
    end else if (wr_rate) begin
      nxt_rate = reg_wdata_i; // R9
    end
  end

  always_comb begin
    nxt_rats = rats_ff;
    if (init_load) begin
      nxt_rats = tag_regs_pkg::RATS_RESET; // R18
    end else if (rats_valid_i && in_level4) begin
      nxt_rats = {rats_frame_size_i, rats_card_ident_i}; // R16 R17 R19
    end
  end

  always_comb begin
    nxt_rdata = 8'h00;
    case (reg_addr_i)
      tag_regs_pkg::ADDR_MODE: nxt_rdata = mode_ff & tag_regs_pkg::MODE_VALID_MASK; // R21
      tag_regs_pkg::ADDR_RATE: nxt_rdata = rate_ff;
      tag_regs_pkg::ADDR_STATE: nxt_rdata = state_view; // R15
      tag_regs_pkg::ADDR_RATS: nxt_rdata = rats_ff;
      default: nxt_rdata = 8'h00;
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Reset clears mode unless the config word loads in the same cycle
  always_ff @(posedge mclk_i) begin
    if (srst_i && !config_load_i) begin
      mode_ff <= 8'h00;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  always_ff @(posedge mclk_i) begin
    rate_ff <= nxt_rate;
    rats_ff <= nxt_rats;
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd_i) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  rate_decode u_tx_rate (
    .code_i(rate_ff[7:4]),
    .sel_o(tx_rate_o)
  );

  rate_decode u_rx_rate (
    .code_i(rate_ff[3:0]),
    .sel_o(rx_rate_o)
  );

  assign op_mode_o = cur_mode; // R1
  assign force_level_four_o = in_level4; // R2
  assign fifo_opts_o = (in_level4 || in_level3 || in_framing) ? reg_opts : '0; // R5
  assign direct_opts_o = (in_level3 || in_framing) ? reg_opts : '0; // R5
  assign reg_rdata_o = rdata_ff;
  assign reg_hit_o = (reg_addr_i == tag_regs_pkg::ADDR_MODE) ||
    (reg_addr_i == tag_regs_pkg::ADDR_RATE) ||
    (reg_addr_i == tag_regs_pkg::ADDR_STATE) ||
    (reg_addr_i == tag_regs_pkg::ADDR_RATS);
  assign set_default_o = set_default;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  sequence s_pps_l4;
    pps_valid_i && in_level4 && !set_default;
  endsequence

  a_mode_reserved: assert property (mode_ff[7:6] == 2'h0) // R21
    else $error("mode reserved bits set");
  a_mode_write: assert property (wr_mode && !config_load_i |=>
    mode_ff == (($past(reg_wdata_i)) & 8'h3F)) // R1
    else $error("mode write lost");
  a_cfg_load: assert property (config_load_i |=>
    mode_ff[5:0] == $past(config_word_i[12:7])) // R8
    else $error("config load wrong");
  a_pps_load: assert property (s_pps_l4 |=>
    rate_ff == {$past(pps_tx_code_i), $past(pps_rx_code_i)}) // R10
    else $error("pps rate not loaded");
  a_default_clear: assert property (set_default |=>
    rate_ff == 8'h00 && rats_ff == 8'h00) // R9 R18 R20
    else $error("default did not clear");
  a_rats_hold: assert property (!in_level4 && !set_default |=> $stable(rats_ff)) // R19
    else $error("rats changed outside level four");
  a_rate_disable: assert property (rate_ff[7:6] != 2'h0 |-> !tx_rate_o.enable) // R12
    else $error("tx enabled on bad code");
  a_state_read: assert property (reg_rd_i && reg_addr_i == 6'h04 |=>
    reg_rdata_o == {$past(field_power_present_i), $past(tag_state_i), 4'h0}) // R13 R14
    else $error("state view wrong");
  a_direct_opts: assert property (in_level4 |-> direct_opts_o == '0) // R5
    else $error("direct options in protocol mode");

endmodule

// ===== src/tag_regs_pkg.sv
// Constants and carrier types for the tag mode, rate and status register group.
// Assumes a byte-wide register port driven by an SPI front end on the same clock.
package tag_regs_pkg;

  // ****************************************************************
  // Register addresses (6-bit)
  // ****************************************************************
  localparam logic [5:0] ADDR_MODE = 6'h01;
  localparam logic [5:0] ADDR_RATE = 6'h02;
  localparam logic [5:0] ADDR_STATE = 6'h04;
  localparam logic [5:0] ADDR_RATS = 6'h05;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int MODE_HI = 5;
  localparam int MODE_LO = 4;
  localparam int RX_NO_CRC_BIT = 3;
  localparam int RX_BITSTREAM_BIT = 2;
  localparam int TX_NO_CRC_BIT = 1;
  localparam int TX_BITSTREAM_BIT = 0;
  localparam int CFG_WORD_HI = 12;
  localparam int CFG_WORD_LO = 7;
  localparam logic [7:0] MODE_VALID_MASK = 8'h3F;
  localparam logic [7:0] RATE_RESET = 8'h00;
  localparam logic [7:0] RATS_RESET = 8'h00;
  localparam logic [7:0] SET_DEFAULT_CMD_A = 8'hC2;
  localparam logic [7:0] SET_DEFAULT_CMD_B = 8'hC3;

  // ****************************************************************
  // Enumerations
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_LEVEL4 = 2'b00,
    MODE_LEVEL3 = 2'b01,
    MODE_FRAMING = 2'b10,
    MODE_TRANSPARENT = 2'b11
  } op_mode_t;

  typedef enum logic [2:0] {
    ST_POWER_OFF = 3'b000,
    ST_IDLE = 3'b001,
    ST_READY = 3'b010,
    ST_ACTIVE = 3'b011,
    ST_LEVEL_FOUR = 3'b100,
    ST_HALT = 3'b101,
    ST_READY_STAR = 3'b110,
    ST_ACTIVE_STAR = 3'b111
  } tag_state_t;

  typedef enum logic [1:0] {
    DIV_128 = 2'b00,
    DIV_64 = 2'b01,
    DIV_32 = 2'b10,
    DIV_16 = 2'b11
  } carrier_div_t;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic rx_no_crc;
    logic rx_bitstream;
    logic tx_no_crc;
    logic tx_bitstream;
  } frame_opts_t;

  typedef struct packed {
    logic enable;
    carrier_div_t div;
  } rate_sel_t;

endpackage

// ===== verif/mcu_host_model.sv
// Host model that drives the register port and direct command strobe.
// Assumes the register block takes requests on the rising edge of mclk_i.
`timescale 1ns/1ps
module mcu_host_model (
  // Clock
  input wire logic mclk_i,
  // Register port
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [5:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i,
  // Direct command
  output logic cmd_valid_o,
  output logic [7:0] cmd_byte_o,
  input wire logic set_default_i
);
  // ********
  // Bus cycles
  // ********
  initial begin
    {reg_wr_o, reg_rd_o, cmd_valid_o, reg_addr_o, reg_wdata_o, cmd_byte_o} = '0;
  end

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= a;
    reg_wdata_o <= d;
    @(posedge mclk_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    reg_rd_o <= 1'b1;
    reg_addr_o <= a;
    @(posedge mclk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    #1;
    d = reg_rdata_i;
  endtask

  // Holds an address on the port with no strobe
  task automatic put_addr(input logic [5:0] a);
    @(posedge mclk_i);
    reg_addr_o <= a;
  endtask

  // Direct command byte sent as a one-cycle strobe
  task automatic cmd(input logic [7:0] b, output logic ack);
    @(posedge mclk_i);
    cmd_valid_o <= 1'b1;
    cmd_byte_o <= b;
    #1;
    ack = set_default_i;
    @(posedge mclk_i);
    cmd_valid_o <= 1'b0;
    cmd_byte_o <= ~b;
  endtask
endmodule

// ===== verif/tag_mode_rate_status_regs_tb.sv
// Self-checking bench for the mode, rate, status and frame/ident registers.
// Assumes the host model in mcu_host_model.sv drives the register port.
`timescale 1ns/1ps
module tag_mode_rate_status_regs_tb;
  logic mclk_i, srst_i, cfg_ld, pps_v, rats_v, fld, sdef, wr, rd, cv, hit, f4, ack;
  logic [15:0] cfg;
  logic [7:0] wd, rdat, cb, d;
  logic [5:0] ad;
  logic [3:0] ptx, prx, rfs, rci;
  tag_regs_pkg::tag_state_t st;
  tag_regs_pkg::op_mode_t om;
  tag_regs_pkg::frame_opts_t fo, dro;
  tag_regs_pkg::rate_sel_t txr, rxr;
  int err_total, compares, seed, mode_m, rate_m, rats_m, m, r;

  tag_mode_rate_status_regs dut_u (.mclk_i(mclk_i), .srst_i(srst_i), .config_word_i(cfg),
    .config_load_i(cfg_ld), .cmd_valid_i(cv), .cmd_byte_i(cb), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(ad), .reg_wdata_i(wd), .reg_rdata_o(rdat), .reg_hit_o(hit),
    .field_power_present_i(fld), .tag_state_i(st), .pps_valid_i(pps_v), .pps_tx_code_i(ptx),
    .pps_rx_code_i(prx), .rats_valid_i(rats_v), .rats_frame_size_i(rfs),
    .rats_card_ident_i(rci), .op_mode_o(om), .force_level_four_o(f4), .fifo_opts_o(fo),
    .direct_opts_o(dro), .tx_rate_o(txr), .rx_rate_o(rxr), .set_default_o(sdef));
  mcu_host_model host_u (.mclk_i(mclk_i), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(ad),
    .reg_wdata_o(wd), .reg_rdata_i(rdat), .cmd_valid_o(cv), .cmd_byte_o(cb),
    .set_default_i(sdef));

  // ********
  // Checking and closing
  // ********
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic results();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  initial begin
    repeat (20000) @(posedge mclk_i);
    err_total++;
    results();
  end

  // ********
  // Scenarios
  // ********
  initial begin
    seed = 66991;
    srst_i = 1'b1;
    cfg_ld = 1'b1;
    cfg = 16'($random(seed));
    {pps_v, rats_v, fld, ptx, prx, rfs, rci} = '0;
    st = tag_regs_pkg::ST_IDLE;
    repeat (3) @(posedge mclk_i);
    srst_i <= 1'b0;
    cfg_ld <= 1'b0;
    mode_m = int'(cfg[12:7]);
    rats_m = 0;
    host_u.rd(tag_regs_pkg::ADDR_MODE, d);
    chk(d, 8'(mode_m));
    for (int a = 0; a < 64; a++) begin
      host_u.put_addr(6'(a));
      #1;
      chk({7'h00, hit}, 8'(a == int'(tag_regs_pkg::ADDR_MODE) ||
        a == int'(tag_regs_pkg::ADDR_RATE) || a == int'(tag_regs_pkg::ADDR_STATE) ||
        a == int'(tag_regs_pkg::ADDR_RATS)));
    end
    for (int i = 0; i < 8; i++) begin
      m = i % 4;
      r = $random(seed) & 15;
      mode_m = m * 16 + r;
      host_u.wr(tag_regs_pkg::ADDR_MODE, 8'(mode_m + 192));
      #1;
      chk({6'h00, om}, 8'(m));
      chk({7'h00, f4}, 8'(m == 0));
      chk({4'h0, fo}, 8'((m != 3) ? r : 0));
      chk({4'h0, dro}, 8'((m == 1 || m == 2) ? r : 0));
      rate_m = $random(seed) & 255;
      host_u.wr(tag_regs_pkg::ADDR_RATE, 8'(rate_m));
      host_u.wr(tag_regs_pkg::ADDR_STATE, 8'($random(seed)));
      host_u.wr(tag_regs_pkg::ADDR_RATS, 8'($random(seed)));
      @(posedge mclk_i);
      {pps_v, rats_v, ptx, prx, rfs, rci} <= {2'b11, 16'($random(seed))};
      fld <= 1'($random(seed));
      st <= tag_regs_pkg::tag_state_t'(3'($random(seed)));
      @(posedge mclk_i);
      {pps_v, rats_v} <= 2'b00;
      if (m == 0) begin
        rate_m = int'({ptx, prx});
        rats_m = int'({rfs, rci});
      end
      host_u.rd(tag_regs_pkg::ADDR_RATE, d);
      chk(d, 8'(rate_m));
      chk({5'h00, txr}, 8'(((rate_m >> 4) < 4 ? 4 : 0) + ((rate_m >> 4) & 3)));
      chk({5'h00, rxr}, 8'(((rate_m & 15) < 4 ? 4 : 0) + (rate_m & 3)));
      host_u.rd(tag_regs_pkg::ADDR_RATS, d);
      chk(d, 8'(rats_m));
      host_u.rd(tag_regs_pkg::ADDR_STATE, d);
      chk(d, {fld, st, 4'h0});
      host_u.rd(tag_regs_pkg::ADDR_MODE, d);
      chk(d, 8'(mode_m));
      host_u.rd(6'h3F, d);
      chk(d, 8'h00);
      if (m == 3) begin
        host_u.cmd(8'hC4, ack);
        chk({7'h00, ack}, 8'h00);
        host_u.cmd(8'(194 + i / 4), ack);
        chk({7'h00, ack}, 8'h01);
        host_u.rd(tag_regs_pkg::ADDR_RATE, d);
        chk(d, 8'h00);
        host_u.rd(tag_regs_pkg::ADDR_RATS, d);
        chk(d, 8'h00);
        rats_m = 0;
      end
      $display("test %0d done", i);
    end
    // Config reload and a second reset in mid-run
    @(posedge mclk_i);
    cfg <= 16'($random(seed));
    cfg_ld <= 1'b1;
    @(posedge mclk_i);
    cfg_ld <= 1'b0;
    host_u.rd(tag_regs_pkg::ADDR_MODE, d);
    chk(d, {2'h0, cfg[12:7]});
    host_u.wr(tag_regs_pkg::ADDR_RATE, 8'hA5);
    @(posedge mclk_i);
    srst_i <= 1'b1;
    @(posedge mclk_i);
    srst_i <= 1'b0;
    host_u.rd(tag_regs_pkg::ADDR_RATE, d);
    chk(d, 8'h00);
    host_u.rd(tag_regs_pkg::ADDR_MODE, d);
    chk(d, 8'h00);
    $display("test reload done");
    results();
  end
endmodule
